// ### test/touch_sensor_irq_logic_tb_top.sv
/*
  Self-checking testbench of the touch sensor interrupt logic.
  Assumes the APB slave answers with pready and a pulled-up host input.
*/
`include "tsirq_map.svh"
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module touch_sensor_irq_logic_tb_top;
  import tsirq_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] stage_done = 12'h000;
  logic [11:0] touch_low  = 12'h000;
  logic [11:0] touch_high = 12'h000;
  logic        gpio_pin   = 1'b0;
  logic        irq_n;
  logic        irq_n_oe;
  logic        irq_line;
  logic [31:0] rd;
  logic        err;
  int          err_count = 0;
  int          tests_run = 0;

  localparam logic [11:0] A_LOW_EN  = {`TSIRQ_IDX_TOUCH_LOW_EN, 2'b00};
  localparam logic [11:0] A_HIGH_EN = {`TSIRQ_IDX_TOUCH_HIGH_EN, 2'b00};
  localparam logic [11:0] A_DONE_EN = {`TSIRQ_IDX_DONE_EN, 2'b00};
  localparam logic [11:0] A_LOW_FL  = {`TSIRQ_IDX_TOUCH_LOW_FLG, 2'b00};
  localparam logic [11:0] A_HIGH_FL = {`TSIRQ_IDX_TOUCH_HIGH_FLG, 2'b00};
  localparam logic [11:0] A_DONE_FL = {`TSIRQ_IDX_DONE_FLG, 2'b00};

  always #5 sys_clk = ~sys_clk;

  tsirq_core dut (
    .sys_clk_in    (sys_clk),
    .rst_b_in      (rst_b),
    .psel_in       (psel),
    .penable_in    (penable),
    .pwrite_in     (pwrite),
    .paddr_in      (paddr),
    .pwdata_in     (pwdata),
    .prdata_out    (prdata),
    .pready_out    (pready),
    .pslverr_out   (pslverr),
    .stage_done_in (stage_done),
    .touch_low_in  (touch_low),
    .touch_high_in (touch_high),
    .gpio_pin_in   (gpio_pin),
    .irq_n_out     (irq_n),
    .irq_n_oe_out  (irq_n_oe)
  );

  tsirq_host_model host (
    .irq_n_in     (irq_n),
    .irq_n_oe_in  (irq_n_oe),
    .irq_line_out (irq_line)
  );

  task final_report;
    begin
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask : final_report

  // one APB transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    begin
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
        @(posedge sys_clk);
        n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task settle;
    begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
    end
  endtask : settle

  task reset_and_map;
    logic [11:0] a;
    begin
      for (int i = 5; i <= 10; i++) begin
        a = 12'(i * 4);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("reset value", 32'h0000_0000, rd)
      end
      apb(1'b0, 12'h02c, 32'h0000_0000);
      `CHK("unmapped error", 1'b1, err)
      apb(1'b1, A_HIGH_EN, 32'hffff_0abc);
      apb(1'b0, A_HIGH_EN, 32'h0000_0000);
      `CHK("high enable readback", 32'h0000_0abc, rd)
      apb(1'b1, A_HIGH_EN, 32'h0000_0000);
      apb(1'b0, 12'h015, 32'h0000_0000);
      `CHK("unaligned error", 1'b1, err)
      apb(1'b1, A_LOW_EN, 32'h0000_b5a5);
      apb(1'b0, A_LOW_EN, 32'h0000_0000);
      `CHK("low enable readback", 32'h0000_b5a5, rd)
      apb(1'b1, A_DONE_EN, 32'hffff_ffff);
      apb(1'b0, A_DONE_EN, 32'h0000_0000);
      `CHK("done enable readback", 32'h0000_1fff, rd)
      apb(1'b1, A_LOW_EN, 32'h0000_0000);
      apb(1'b1, A_DONE_EN, 32'h0000_0000);
    end
  endtask : reset_and_map

  task done_case;
    begin
      apb(1'b1, A_DONE_EN, 32'h0000_0008);
      @(posedge sys_clk);
      stage_done <= 12'h010;
      @(posedge sys_clk);
      stage_done <= 12'h000;
      settle();
      `CHK("disabled stage line", 1'b1, irq_line)
      @(posedge sys_clk);
      stage_done <= 12'h008;
      @(posedge sys_clk);
      stage_done <= 12'h000;
      settle();
      `CHK("done line low", 1'b0, irq_line)
      apb(1'b0, A_DONE_FL, 32'h0000_0000);
      `CHK("done flags", 32'h0000_0008, rd)
      @(negedge sys_clk);
      `CHK("line released by read", 1'b1, irq_line)
      apb(1'b0, A_DONE_FL, 32'h0000_0000);
      `CHK("done flags cleared", 32'h0000_0000, rd)
      @(posedge sys_clk);
      stage_done <= 12'h008;
      @(posedge sys_clk);
      stage_done <= 12'h000;
      settle();
      apb(1'b1, A_DONE_FL, 32'h0000_0000);
      @(negedge sys_clk);
      `CHK("write zero keeps flag", 1'b0, irq_line)
      apb(1'b1, A_DONE_FL, 32'h0000_0008);
      @(negedge sys_clk);
      `CHK("write one clears flag", 1'b1, irq_line)
    end
  endtask : done_case

  task touch_case;
    begin
      apb(1'b1, A_LOW_EN, 32'h0000_0001);
      apb(1'b1, A_HIGH_EN, 32'h0000_0020);
      @(posedge sys_clk);
      touch_low <= 12'h001;
      settle();
      `CHK("contact line low", 1'b0, irq_line)
      apb(1'b0, A_LOW_FL, 32'h0000_0000);
      `CHK("low activations", 32'h0000_0001, rd)
      @(negedge sys_clk);
      `CHK("low read releases", 1'b1, irq_line)
      @(posedge sys_clk);
      touch_low <= 12'h000;
      touch_high <= 12'h020;
      settle();
      `CHK("release line low", 1'b0, irq_line)
      apb(1'b0, A_LOW_FL, 32'h0000_0000);
      `CHK("low after release", 32'h0000_0000, rd)
      @(negedge sys_clk);
      `CHK("high still pending", 1'b0, irq_line)
      apb(1'b0, A_HIGH_FL, 32'h0000_0000);
      `CHK("high activations", 32'h0000_0020, rd)
      @(posedge sys_clk);
      touch_high <= 12'h000;
      settle();
      apb(1'b0, A_HIGH_FL, 32'h0000_0000);
      @(negedge sys_clk);
      `CHK("touch idle line", 1'b1, irq_line)
      apb(1'b1, A_LOW_EN, 32'h0000_0000);
      apb(1'b1, A_HIGH_EN, 32'h0000_0000);
    end
  endtask : touch_case

  task pin_case;
    logic act;
    logic lvl;
    begin
      apb(1'b1, A_DONE_EN, 32'h0000_1000);
      apb(1'b1, A_LOW_EN, 32'h0000_4000);
      @(posedge sys_clk);
      gpio_pin <= 1'b1;
      settle();
      `CHK("pin ignored when off", 1'b1, irq_line)
      for (int t = 0; t < 4; t++) begin
        act = t[0];
        lvl = (t[0] == t[1]);
        @(posedge sys_clk);
        gpio_pin <= ~act;
        apb(1'b1, A_LOW_EN, {16'h0000, t[1:0], 2'b01, 12'h000});
        settle();
        apb(1'b0, A_DONE_FL, 32'h0000_0000);
        @(negedge sys_clk);
        `CHK("pin idle line", 1'b1, irq_line)
        @(posedge sys_clk);
        gpio_pin <= act;
        settle();
        `CHK("pin trigger line", 1'b0, irq_line)
        apb(1'b0, A_DONE_FL, 32'h0000_0000);
        `CHK("pin status", 32'h0000_1000, rd)
        @(negedge sys_clk);
        `CHK("line after read", ~lvl, irq_line)
        @(posedge sys_clk);
        gpio_pin <= ~act;
        settle();
        apb(1'b0, A_DONE_FL, 32'h0000_0000);
        @(negedge sys_clk);
        `CHK("pin cleared line", 1'b1, irq_line)
      end
      apb(1'b1, A_DONE_EN, 32'h0000_0000);
      @(posedge sys_clk);
      gpio_pin <= act;
      settle();
      `CHK("pin disabled line", 1'b1, irq_line)
    end
  endtask : pin_case

  // reset in mid-run with a flag standing
  task reset_case;
    begin
      apb(1'b1, A_DONE_EN, 32'h0000_0001);
      @(posedge sys_clk);
      stage_done <= 12'h001;
      @(posedge sys_clk);
      stage_done <= 12'h000;
      settle();
      `CHK("flag before reset", 1'b0, irq_line)
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      `CHK("line after mid reset", 1'b1, irq_line)
      apb(1'b0, A_DONE_EN, 32'h0000_0000);
      `CHK("enable after mid reset", 32'h0000_0000, rd)
      apb(1'b0, A_DONE_FL, 32'h0000_0000);
      `CHK("flags after mid reset", 32'h0000_0000, rd)
    end
  endtask : reset_case

  initial begin
    #200000;
    err_count++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    `CHK("line after reset", 1'b1, irq_line)
    reset_and_map();
    done_case();
    touch_case();
    pin_case();
    reset_case();
    final_report();
  end
endmodule : touch_sensor_irq_logic_tb_top

`default_nettype wire

// ### test/tsirq_host_model.sv
/*
  Host side of the interrupt line: an input with a pull-up resistor.
  Assumes the device pulls the line low only while its output enable is high.
*/
`timescale 1ns/1ns
`default_nettype none

module tsirq_host_model (
  input  wire logic irq_n_in,
  input  wire logic irq_n_oe_in,
  output logic      irq_line_out
);
  // released line floats to the pull-up level
  assign irq_line_out = irq_n_oe_in ? irq_n_in : 1'b1;
endmodule : tsirq_host_model

`default_nettype wire

// ### verilog/tsirq_core.sv
/*
  Interrupt logic of a capacitance-sensor controller: enable and status
  registers on APB, one open-drain active-low interrupt line.
  Assumes stage completion pulses, touch threshold levels and the
  general-purpose pin all arrive synchronous to sys_clk_in.
*/
// Implementation choice: the APB register port.
// What this block does
// - one open-drain active-low interrupt line combining completion, touch and pin events
// - status read clears flags and releases line at address phase
// - enabled stage completion with new result pulls the line low
// - completion enable register holds one enable bit per stage
// - completion flags set per fired stage; read clears only absent conditions
// - touch mode interrupts on contact and again on release
// - separate per-stage enables for low and high threshold crossings
// - low and high touch status registers; line low until read
// - any touch status change interrupts; reads return present activations
// - pin interrupts only while pin setup selects input
// - pin interrupt enable bit lives in completion enable register
// - pin status bit set on trigger; read clears once cause ended
// - negative level mode holds status while pin low
// - positive edge mode triggers on low to high change
// - negative edge mode triggers on high to low change
// - positive level mode holds status while pin high
// - pin setup field sits at bits 13 to 12 of low enable
`include "tsirq_map.svh"
`timescale 1ns/1ns
`default_nettype none

module tsirq_core
  import tsirq_pkg::*;
(
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_b_in,
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [`TSIRQ_ADDR_W-1:0]     paddr_in,
  input  wire logic [31:0]                  pwdata_in,
  output logic      [31:0]                  prdata_out,
  output logic                              pready_out,
  output logic                              pslverr_out,
  input  wire logic [`TSIRQ_STAGES-1:0]     stage_done_in,
  input  wire logic [`TSIRQ_STAGES-1:0]     touch_low_in,
  input  wire logic [`TSIRQ_STAGES-1:0]     touch_high_in,
  input  wire logic                         gpio_pin_in,
  output logic                              irq_n_out,
  output logic                              irq_n_oe_out
);
  localparam int S = `TSIRQ_STAGES;

  logic [`TSIRQ_REG_W-1:0] touch_low_irq_enable_reg;
  logic [S-1:0]            touch_high_irq_enable_reg;
  logic [S-1:0]            stage_done_irq_enable_reg;
  logic                    pin_irq_enable_reg;
  logic [S-1:0]            stage_done_irq_flags_reg;
  logic [S-1:0]            stage_done_irq_flags_next;
  logic                    pin_flag_reg;
  logic                    pin_flag_next;
  logic [S-1:0]            touch_low_act_reg;
  logic [S-1:0]            touch_high_act_reg;
  logic                    touch_low_pend_reg;
  logic                    touch_low_pend_next;
  logic                    touch_high_pend_reg;
  logic                    touch_high_pend_next;
  logic [31:0]             prdata_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic                    irq_oe_reg;
  logic                    irq_n_reg;

  tsirq_pin_setup_t        pin_setup;
  tsirq_trig_t             pin_trig;
  logic                    pin_armed;
  logic                    pin_cond;
  logic [S-1:0]            done_cond;
  logic [S-1:0]            touch_low_act;
  logic [S-1:0]            touch_high_act;
  logic                    touch_low_chg;
  logic                    touch_high_chg;

  logic                    setup_ph;
  logic                    rd_setup;
  logic                    wr_fire;
  logic                    addr_ok;
  logic [9:0]              idx;
  logic                    hit_low_en;
  logic                    hit_high_en;
  logic                    hit_done_en;
  logic                    hit_low_flg;
  logic                    hit_high_flg;
  logic                    hit_done_flg;
  logic                    hit_any;
  logic [S-1:0]            done_clr;
  logic                    pin_clr;
  logic                    low_clr;
  logic                    high_clr;
  logic [31:0]             rd_value;

  // field decode of the enable registers
  assign pin_setup = tsirq_pin_setup_t'(
    touch_low_irq_enable_reg[`TSIRQ_PIN_SETUP_MSB:`TSIRQ_PIN_SETUP_LSB]);
  assign pin_trig  = tsirq_trig_t'(
    touch_low_irq_enable_reg[`TSIRQ_PIN_TRIG_MSB:`TSIRQ_PIN_TRIG_LSB]);
  assign pin_armed = (pin_setup == TSIRQ_PIN_INPUT) && pin_irq_enable_reg;

  tsirq_pin_trigger u_pin_trigger (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .pin_in     (gpio_pin_in),
    .mode_in    (pin_trig),
    .armed_in   (pin_armed),
    .cond_out   (pin_cond)
  );

  // address decode
  assign setup_ph     = psel_in && !penable_in;
  assign idx          = paddr_in[`TSIRQ_ADDR_W-1:2];
  assign addr_ok      = (paddr_in[1:0] == 2'b00);
  assign hit_low_en   = addr_ok && (idx == `TSIRQ_IDX_TOUCH_LOW_EN);
  assign hit_high_en  = addr_ok && (idx == `TSIRQ_IDX_TOUCH_HIGH_EN);
  assign hit_done_en  = addr_ok && (idx == `TSIRQ_IDX_DONE_EN);
  assign hit_low_flg  = addr_ok && (idx == `TSIRQ_IDX_TOUCH_LOW_FLG);
  assign hit_high_flg = addr_ok && (idx == `TSIRQ_IDX_TOUCH_HIGH_FLG);
  assign hit_done_flg = addr_ok && (idx == `TSIRQ_IDX_DONE_FLG);
  assign hit_any      = hit_low_en || hit_high_en || hit_done_en ||
                        hit_low_flg || hit_high_flg || hit_done_flg;
  assign rd_setup     = setup_ph && !pwrite_in;
  assign wr_fire      = psel_in && penable_in && pwrite_in && pready_reg;

  // clears: read at address phase, or write one to a flag bit
  always_comb begin
    done_clr = '0;
    pin_clr  = 1'b0;
    low_clr  = 1'b0;
    high_clr = 1'b0;
    if (rd_setup && hit_done_flg) begin
      done_clr = '1;
      pin_clr  = 1'b1;
    end
    if (wr_fire && hit_done_flg) begin
      done_clr = pwdata_in[S-1:0];
      pin_clr  = pwdata_in[`TSIRQ_PIN_FLG_BIT];
    end
    if (rd_setup && hit_low_flg) begin
      low_clr = 1'b1;
    end
    if (rd_setup && hit_high_flg) begin
      high_clr = 1'b1;
    end
    if (wr_fire && hit_low_flg) begin
      low_clr = |pwdata_in[S-1:0];
    end
    if (wr_fire && hit_high_flg) begin
      high_clr = |pwdata_in[S-1:0];
    end
  end

  // event conditions; a present condition wins over a clear
  assign done_cond      = stage_done_in & stage_done_irq_enable_reg;
  assign touch_low_act  = touch_low_in & touch_low_irq_enable_reg[S-1:0];
  assign touch_high_act = touch_high_in & touch_high_irq_enable_reg;
  assign touch_low_chg  = (touch_low_act != touch_low_act_reg);
  assign touch_high_chg = (touch_high_act != touch_high_act_reg);

  assign stage_done_irq_flags_next =
    (stage_done_irq_flags_reg & ~done_clr) | done_cond;
  assign pin_flag_next        = (pin_flag_reg && !pin_clr) || pin_cond;
  assign touch_low_pend_next  = (touch_low_pend_reg && !low_clr) || touch_low_chg;
  assign touch_high_pend_next = (touch_high_pend_reg && !high_clr) || touch_high_chg;

  // enable registers
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      touch_low_irq_enable_reg  <= `TSIRQ_EN_RESET;
      touch_high_irq_enable_reg <= '0;
      stage_done_irq_enable_reg <= '0;
      pin_irq_enable_reg        <= 1'b0;
    end else if (wr_fire) begin
      if (hit_low_en) begin
        touch_low_irq_enable_reg <= pwdata_in[`TSIRQ_REG_W-1:0];
      end
      if (hit_high_en) begin
        touch_high_irq_enable_reg <= pwdata_in[S-1:0];
      end
      if (hit_done_en) begin
        stage_done_irq_enable_reg <= pwdata_in[S-1:0];
        pin_irq_enable_reg        <= pwdata_in[`TSIRQ_PIN_EN_BIT];
      end
    end
  end

  // sticky flags
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage_done_irq_flags_reg <= '0;
      pin_flag_reg             <= 1'b0;
      touch_low_pend_reg       <= 1'b0;
      touch_high_pend_reg      <= 1'b0;
    end else begin
      stage_done_irq_flags_reg <= stage_done_irq_flags_next;
      pin_flag_reg             <= pin_flag_next;
      touch_low_pend_reg       <= touch_low_pend_next;
      touch_high_pend_reg      <= touch_high_pend_next;
    end
  end

  // present touch activations
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      touch_low_act_reg  <= '0;
      touch_high_act_reg <= '0;
    end else begin
      touch_low_act_reg  <= touch_low_act;
      touch_high_act_reg <= touch_high_act;
    end
  end

  // interrupt line, pulled low while any flag stands
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_oe_reg <= 1'b0;
      irq_n_reg  <= 1'b0;
    end else begin
      irq_oe_reg <= (|stage_done_irq_flags_next) || pin_flag_next ||
                    touch_low_pend_next || touch_high_pend_next;
      irq_n_reg  <= 1'b0;
    end
  end

  // read mux, sampled before the clear lands
  always_comb begin
    rd_value = '0;
    if (hit_low_en) begin
      rd_value[`TSIRQ_REG_W-1:0] = touch_low_irq_enable_reg;
    end
    if (hit_high_en) begin
      rd_value[S-1:0] = touch_high_irq_enable_reg;
    end
    if (hit_done_en) begin
      rd_value[S-1:0]               = stage_done_irq_enable_reg;
      rd_value[`TSIRQ_PIN_EN_BIT]   = pin_irq_enable_reg;
    end
    if (hit_low_flg) begin
      rd_value[S-1:0] = touch_low_act_reg;
    end
    if (hit_high_flg) begin
      rd_value[S-1:0] = touch_high_act_reg;
    end
    if (hit_done_flg) begin
      rd_value[S-1:0]             = stage_done_irq_flags_reg;
      rd_value[`TSIRQ_PIN_FLG_BIT] = pin_flag_reg;
    end
  end

  // apb answer: zero wait states
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph && !hit_any;
      if (rd_setup) begin
        prdata_reg <= rd_value;
      end
    end
  end

  assign prdata_out   = prdata_reg;
  assign pready_out   = pready_reg;
  assign pslverr_out  = pslverr_reg;
  assign irq_n_out    = irq_n_reg;
  assign irq_n_oe_out = irq_oe_reg;

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  chk_apb_ready_next: assert property (
    setup_ph |=> pready_out ##1 !pready_out
  ) else $error("pready not a single cycle after setup");

  chk_done_pulls_line: assert property (
    (|done_cond) |=> irq_n_oe_out && ((stage_done_irq_flags_reg & $past(done_cond)) == $past(done_cond))
  ) else $error("enabled completion did not pull the line");

  chk_done_read_clear: assert property (
    (rd_setup && hit_done_flg && done_cond == '0 && !pin_cond)
      |=> stage_done_irq_flags_reg == '0 && !pin_flag_reg
  ) else $error("completion flags not cleared by read");

  chk_read_keeps_cond: assert property (
    (rd_setup && hit_done_flg && pin_cond) |=> pin_flag_reg && irq_n_oe_out
  ) else $error("read cleared a present condition");

  chk_neg_level_hold: assert property (
    (pin_armed && pin_trig == TSIRQ_TRIG_NEG_LEVEL && !gpio_pin_in) |=> pin_flag_reg && irq_n_oe_out
  ) else $error("negative level not holding the line");

  chk_pos_edge_sets: assert property (
    (pin_armed && pin_trig == TSIRQ_TRIG_POS_EDGE && $rose(gpio_pin_in)) |=> pin_flag_reg
  ) else $error("rising pin edge missed");

  chk_neg_edge_sets: assert property (
    (pin_armed && pin_trig == TSIRQ_TRIG_NEG_EDGE && $fell(gpio_pin_in)) |=> pin_flag_reg
  ) else $error("falling pin edge missed");

  chk_pin_gated_off: assert property (
    (!pin_flag_reg && pin_setup != TSIRQ_PIN_INPUT) |=> !pin_flag_reg
  ) else $error("pin set status while not an input");

  chk_touch_change: assert property (
    (touch_low_chg || touch_high_chg) |=> irq_n_oe_out [*2] or (irq_n_oe_out ##1 1'b1)
  ) else $error("touch change did not pull the line");

  chk_line_released: assert property (
    !$past(rd_setup || wr_fire) |-> !$fell(irq_n_oe_out)
  ) else $error("line released without a host access");

  chk_unmapped_error: assert property (
    (setup_ph && !hit_any) |=> pslverr_out && pready_out
  ) else $error("unmapped access not flagged");

  chk_read_releases_line: assert property (
    (rd_setup && hit_done_flg && done_cond == '0 && !pin_cond &&
     !touch_low_pend_reg && !touch_high_pend_reg && !touch_low_chg && !touch_high_chg)
      |=> !irq_n_oe_out
  ) else $error("read did not release the line in the access cycle");

  chk_touch_read_clear: assert property (
    (rd_setup && hit_low_flg && !touch_low_chg) |=> !touch_low_pend_reg
  ) else $error("low touch read did not clear pending");

  chk_pos_level_hold: assert property (
    (pin_armed && pin_trig == TSIRQ_TRIG_POS_LEVEL && gpio_pin_in) |=> pin_flag_reg && irq_n_oe_out
  ) else $error("positive level not holding the line");

  chk_pin_disarmed: assert property (
    (!pin_flag_reg && !pin_irq_enable_reg) |=> !pin_flag_reg
  ) else $error("pin set status while its interrupt is disabled");
endmodule : tsirq_core

`default_nettype wire

// ### verilog/tsirq_map.svh
/*
  Register indices, field positions and reset values of the touch sensor
  interrupt logic. Assumes an APB master with 32-bit data, one word per register.
*/
`ifndef TSIRQ_MAP_SVH
`define TSIRQ_MAP_SVH

`define TSIRQ_IDX_TOUCH_LOW_EN   10'h005
`define TSIRQ_IDX_TOUCH_HIGH_EN  10'h006
`define TSIRQ_IDX_DONE_EN        10'h007
`define TSIRQ_IDX_TOUCH_LOW_FLG  10'h008
`define TSIRQ_IDX_TOUCH_HIGH_FLG 10'h009
`define TSIRQ_IDX_DONE_FLG       10'h00a

`define TSIRQ_STAGES             12
`define TSIRQ_ADDR_W             12
`define TSIRQ_REG_W              16
`define TSIRQ_STAGE_MSB          11
`define TSIRQ_PIN_SETUP_LSB      12
`define TSIRQ_PIN_SETUP_MSB      13
`define TSIRQ_PIN_TRIG_LSB       14
`define TSIRQ_PIN_TRIG_MSB       15
`define TSIRQ_PIN_EN_BIT         12
`define TSIRQ_PIN_FLG_BIT        12
`define TSIRQ_EN_RESET           16'h0000

`endif

// ### verilog/tsirq_pin_trigger.sv
/*
  Trigger detector for the general-purpose input pin.
  Assumes the pin is synchronous to sys_clk_in.
*/
`timescale 1ns/1ns
`default_nettype none

module tsirq_pin_trigger
  import tsirq_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        pin_in,
  input  wire tsirq_trig_t mode_in,
  input  wire logic        armed_in,
  output logic             cond_out
);
  logic pin_prev_reg;
  logic hit;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_in;
    end
  end

  always_comb begin
    hit = 1'b0;
    unique case (mode_in)
      TSIRQ_TRIG_NEG_LEVEL: hit = !pin_in;
      TSIRQ_TRIG_POS_EDGE:  hit = pin_in && !pin_prev_reg;
      TSIRQ_TRIG_NEG_EDGE:  hit = !pin_in && pin_prev_reg;
      TSIRQ_TRIG_POS_LEVEL: hit = pin_in;
    endcase
    cond_out = armed_in && hit;
  end
endmodule : tsirq_pin_trigger

`default_nettype wire

// ### verilog/tsirq_pkg.sv
/*
  Types of the touch sensor interrupt logic: pin setup and pin trigger modes.
  Assumes nothing of its surroundings.
*/
package tsirq_pkg;
  typedef enum logic [1:0] {
    TSIRQ_PIN_OFF,
    TSIRQ_PIN_INPUT,
    TSIRQ_PIN_OUT_LOW,
    TSIRQ_PIN_OUT_HIGH
  } tsirq_pin_setup_t;

  typedef enum logic [1:0] {
    TSIRQ_TRIG_NEG_LEVEL,
    TSIRQ_TRIG_POS_EDGE,
    TSIRQ_TRIG_NEG_EDGE,
    TSIRQ_TRIG_POS_LEVEL
  } tsirq_trig_t;
endpackage : tsirq_pkg
